// ### hdl/setup_cfg_pkg.sv
package setup_cfg_pkg;

    // ****************************************
    // Geometry
    // ****************************************
    localparam int SETUP_COUNT = 8;
    localparam int SETUP_IDX_W = 3;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 4;

    // ****************************************
    // Register map (word offsets)
    // ****************************************
    localparam logic [ADDR_W-1:0] SETUP_CFG_BASE = 4'h0;
    localparam logic [ADDR_W-1:0] ACTIVE_SETUP_OFS = 4'h8;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int RSVD_HI = 15;
    localparam int RSVD_LO = 12;
    localparam int POLARITY_BIT = 11;
    localparam int BURNOUT_HI = 10;
    localparam int BURNOUT_LO = 9;
    localparam int POS_REF_BUF_BIT = 8;
    localparam int NEG_REF_BUF_BIT = 7;
    localparam int POS_IN_BUF_BIT = 6;
    localparam int NEG_IN_BUF_BIT = 5;
    localparam int REFSEL_HI = 4;
    localparam int REFSEL_LO = 3;
    localparam int GAIN_HI = 2;
    localparam int GAIN_LO = 0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [WORD_W-1:0] SETUP_CFG_RESET = 16'h0860;
    localparam logic [SETUP_IDX_W-1:0] ACTIVE_SETUP_RESET = 3'h0;

    // ****************************************
    // Encodings
    // ****************************************
    typedef enum logic [1:0] {
        BURNOUT_OFF = 2'h0,
        BURNOUT_0P5UA = 2'h1,
        BURNOUT_2UA = 2'h2,
        BURNOUT_4UA = 2'h3
    } burnout_t;

    typedef enum logic [1:0] {
        REF_EXT1 = 2'h0,
        REF_EXT2 = 2'h1,
        REF_INTERNAL = 2'h2,
        REF_RESERVED = 2'h3
    } ref_sel_t;

    // Decoded setup presented to the front end
    typedef struct packed {
        logic bipolar;
        logic burnout_en;
        burnout_t burnout_level;
        logic pos_reference_buffer_en;
        logic neg_reference_buffer_en;
        logic pos_input_buffer_en;
        logic neg_input_buffer_en;
        logic use_first_external_reference;
        logic use_second_external_reference;
        logic use_internal_reference;
        logic [2:0] gain_select;
    } front_end_t;

    // Register port bundle
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage

// ### hdl/setup_word_mem.sv
`timescale 1ns/100ps
`default_nettype none
module setup_word_mem
    import setup_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Write port
    input wire logic wr_en,
    input wire logic [SETUP_IDX_W-1:0] wr_idx,
    input wire logic [WORD_W-1:0] wr_data,
    // Registered read ports
    input wire logic [SETUP_IDX_W-1:0] rd_idx,
    output logic [WORD_W-1:0] rd_data,
    input wire logic [SETUP_IDX_W-1:0] sel_idx,
    output logic [WORD_W-1:0] sel_data
);

    typedef struct packed {
        logic [SETUP_COUNT-1:0][WORD_W-1:0] word;
        logic [WORD_W-1:0] rd;
        logic [WORD_W-1:0] sel;
    } mem_state_t;

    mem_state_t s_r;
    mem_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        // Eight independent words, one per setup
        for (int i = 0; i < SETUP_COUNT; i++) begin
            if (wr_en && (wr_idx == i[SETUP_IDX_W-1:0])) begin
                s_nxt.word[i] = wr_data;
            end
        end
        s_nxt.rd = s_r.word[rd_idx];
        s_nxt.sel = s_r.word[sel_idx];
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < SETUP_COUNT; i++) begin
                s_r.word[i] <= SETUP_CFG_RESET;
            end
            s_r.rd <= '0;
            s_r.sel <= SETUP_CFG_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rd_data = s_r.rd;
    assign sel_data = s_r.sel;

endmodule
`default_nettype wire

// ### hdl/setup_cfg_bank.sv
`timescale 1ns/100ps
`default_nettype none
module setup_cfg_bank
    import setup_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [WORD_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [WORD_W-1:0] rdata,
    // Setup of the conversion in progress, from the sequencer
    input wire logic [SETUP_IDX_W-1:0] conv_setup,
    // Front end controls
    output front_end_t front_end
);

    // ****************************************
    // Address decode
    // ****************************************
    function automatic logic is_setup_addr(input logic [ADDR_W-1:0] a);
        return a < ACTIVE_SETUP_OFS;
    endfunction

    function automatic logic is_active_addr(input logic [ADDR_W-1:0] a);
        return a == ACTIVE_SETUP_OFS;
    endfunction

    // ****************************************
    // Field decode
    // ****************************************
    // Detect current level and its switch come from one code
    function automatic burnout_t burnout_code(input logic [WORD_W-1:0] w);
        burnout_t b;
        case (w[BURNOUT_HI:BURNOUT_LO])
            2'h0: b = BURNOUT_OFF;
            2'h1: b = BURNOUT_0P5UA;
            2'h2: b = BURNOUT_2UA;
            2'h3: b = BURNOUT_4UA;
            default: b = BURNOUT_OFF;
        endcase
        return b;
    endfunction

    // One-hot source select; reserved code 11 connects no reference
    function automatic logic [2:0] ref_onehot(input logic [WORD_W-1:0] w);
        logic [2:0] r;
        case (w[REFSEL_HI:REFSEL_LO])
            REF_EXT1: r = 3'h4;
            REF_EXT2: r = 3'h2;
            REF_INTERNAL: r = 3'h1;
            default: r = 3'h0;
        endcase
        return r;
    endfunction

    function automatic front_end_t decode_word(input logic [WORD_W-1:0] w);
        front_end_t f;
        logic [2:0] src;
        src = ref_onehot(w);
        f.bipolar = w[POLARITY_BIT];
        f.burnout_level = burnout_code(w);
        f.burnout_en = (burnout_code(w) != BURNOUT_OFF);
        f.pos_reference_buffer_en = w[POS_REF_BUF_BIT];
        f.neg_reference_buffer_en = w[NEG_REF_BUF_BIT];
        f.pos_input_buffer_en = w[POS_IN_BUF_BIT];
        f.neg_input_buffer_en = w[NEG_IN_BUF_BIT];
        f.use_first_external_reference = src[2];
        f.use_second_external_reference = src[1];
        f.use_internal_reference = src[0];
        f.gain_select = w[GAIN_HI:GAIN_LO];
        return f;
    endfunction

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic rd_pend;
        logic rd_is_setup;
        logic [WORD_W-1:0] rdata;
        front_end_t fe;
        logic [SETUP_IDX_W-1:0] active_setup;
    } bank_state_t;

    bank_state_t s_r;
    bank_state_t s_nxt;
    logic [WORD_W-1:0] mem_rd;
    logic [WORD_W-1:0] mem_sel;
    logic [SETUP_IDX_W-1:0] sel_idx;
    logic wr_setup;
    logic wr_active;
    logic rd_active;

    // ****************************************
    // Request decode
    // ****************************************
    // Rows 9 to 15 decode to nothing: writes drop, reads return zero
    assign wr_setup = wr && is_setup_addr(addr);
    assign wr_active = wr && is_active_addr(addr);
    assign rd_active = rd && is_active_addr(addr);

    // ****************************************
    // Conversion setup select
    // ****************************************
    // Conversion setup is the sequencer index XORed with the active setup register;
    // a nonzero value there remaps every setup index rather than pinning one.
    assign sel_idx = conv_setup ^ s_r.active_setup;

    // ****************************************
    // Setup words
    // ****************************************
    // Words are kept as written; upper bits are not masked so software can
    // read back what it wrote, even an unsupported value.
    setup_word_mem u_mem (
        .clk(clk),
        .rstn(rstn),
        .wr_en(wr_setup),
        .wr_idx(addr[SETUP_IDX_W-1:0]),
        .wr_data(wdata),
        .rd_idx(addr[SETUP_IDX_W-1:0]),
        .rd_data(mem_rd),
        .sel_idx(sel_idx),
        .sel_data(mem_sel)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.rd_pend = rd;
        s_nxt.rd_is_setup = is_setup_addr(addr);
        if (wr_active) begin
            s_nxt.active_setup = wdata[SETUP_IDX_W-1:0];
        end
        // Read data stand only in the cycle after the strobe
        s_nxt.rdata = '0;
        if (rd_active) begin
            s_nxt.rdata = {{(WORD_W-SETUP_IDX_W){1'b0}}, s_r.active_setup};
        end
        // Whole setup word is applied at once to the conversion
        s_nxt.fe = decode_word(mem_sel);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_r.rd_pend <= 1'b0;
            s_r.rd_is_setup <= 1'b0;
            s_r.rdata <= '0;
            s_r.fe <= decode_word(SETUP_CFG_RESET);
            s_r.active_setup <= ACTIVE_SETUP_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Memory read data are a flip-flop; muxed by a registered select
    assign rdata = (s_r.rd_pend && s_r.rd_is_setup) ? mem_rd : s_r.rdata;
    assign front_end = s_r.fe;

endmodule
`default_nettype wire

// ### verification/setup_cfg_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module setup_cfg_monitor
    import setup_cfg_pkg::*;
(
    // Bank ports
    input wire logic clk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [WORD_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [WORD_W-1:0] rdata,
    input wire logic [SETUP_IDX_W-1:0] conv_setup,
    input wire front_end_t front_end
);
    logic [WORD_W-1:0] sh_r [SETUP_COUNT];
    logic [WORD_W-1:0] w, w1_r, w2_r, rx_r;
    logic [SETUP_IDX_W-1:0] ov_r;
    assign w = sh_r[conv_setup ^ ov_r];
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sh_r <= '{default: SETUP_CFG_RESET};
            ov_r <= '0;
        end else if (wr && addr < ACTIVE_SETUP_OFS) begin
            sh_r[addr[2:0]] <= wdata;
        end else if (wr && addr == ACTIVE_SETUP_OFS) begin
            ov_r <= wdata[2:0];
        end
        w1_r <= w;
        w2_r <= w1_r;
        rx_r <= sh_r[addr[2:0]];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Front end lags its setup word by two flops
    sequence setup_read;
        rd && addr < ACTIVE_SETUP_OFS;
    endsequence
    chk_polarity_bit: assert property (front_end.bipolar == w2_r[11])
        else $error("polarity wrong");
    chk_detect_off: assert property (w2_r[10:9] == 2'h0 |-> !front_end.burnout_en)
        else $error("detect current on");
    chk_detect_level: assert property (|w2_r[10:9] |-> front_end[12:10] == {1'b1, w2_r[10:9]})
        else $error("detect level wrong");
    chk_ref_buffers: assert property (front_end[9:8] == w2_r[8:7])
        else $error("reference buffers wrong");
    chk_input_buffers: assert property (front_end[7:6] == w2_r[6:5])
        else $error("input buffers wrong");
    chk_ref_source: assert property (front_end[5:3] == {w2_r[4:3] == 2'h0,
        w2_r[4:3] == 2'h1, w2_r[4:3] == 2'h2})
        else $error("reference source wrong");
    chk_gain_field: assert property (front_end.gain_select == w2_r[2:0])
        else $error("gain wrong");
    chk_setup_read: assert property (setup_read |=> rdata == rx_r)
        else $error("read data wrong");
endmodule
bind setup_cfg_bank setup_cfg_monitor mon (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .conv_setup(conv_setup), .front_end(front_end));
`default_nettype wire

// ### verification/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model
    import setup_cfg_pkg::*;
(
    // Clock and read data
    input wire logic clk,
    input wire logic [WORD_W-1:0] rdata,
    // Requests
    output logic [ADDR_W-1:0] addr,
    output logic [WORD_W-1:0] wdata,
    output logic wr,
    output logic rd
);
    initial begin
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
    end
    // Released lines show junk so stale values never pass
    task automatic idle();
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        addr <= ~addr;
        wdata <= ~wdata;
    endtask
    task automatic wr_word(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] v);
        @(posedge clk);
        wr <= 1'b1;
        rd <= 1'b0;
        addr <= a;
        wdata <= {4'h0, v[11:5], (v[4:3] == 2'h3) ? 2'h2 : v[4:3], v[2:0]};
    endtask
    task automatic rd_word(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] v);
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        @(negedge clk);
        v = rdata;
    endtask
endmodule
`default_nettype wire

// ### verification/setup_cfg_bank_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module setup_cfg_bank_tb
    import setup_cfg_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [SETUP_IDX_W-1:0] conv_setup = '0;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata, rdata, d, w;
    logic wr, rd;
    front_end_t front_end;
    int n_fail = 0;
    int compares = 0;
    int seed = 32'ha700;
    int ov = 0;
    int mem [8];
    always #12.5 clk = ~clk;
    host_model host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
    setup_cfg_bank dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .conv_setup(conv_setup), .front_end(front_end));
    function automatic front_end_t dec(input logic [15:0] v);
        return front_end_t'({v[11], |v[10:9], v[10:9], v[8:5], v[4:3] == 2'h0,
            v[4:3] == 2'h1, v[4:3] == 2'h2, v[2:0]});
    endfunction
    task automatic reset_dut();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        ov = 0;
        foreach (mem[i]) mem[i] = 32'h0860;
    endtask
    task automatic fe_check(input int s);
        @(posedge clk);
        conv_setup <= 3'(s);
        repeat (3) @(posedge clk);
        @(negedge clk);
        `CHK(front_end, dec(16'(mem[(s ^ ov) & 7])))
    endtask
    task automatic finish_test();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        reset_dut();
        fe_check(0);
        for (int i = 0; i < 8; i++) begin
            host.rd_word(4'(i), d);
            `CHK(d, 16'h0860)
        end
        for (int i = 0; i < 16; i++) begin
            w = 16'($random(seed));
            w = {4'h0, w[11], 2'(i % 4), w[8:5], 2'(i % 3), w[2:0]};
            mem[i % 8] = int'(w);
            host.wr_word(4'(i % 8), w);
            host.rd_word(4'(i % 8), d);
            `CHK(d, w)
            fe_check(i % 8);
        end
        for (int a = 9; a < 16; a++) host.wr_word(4'(a), 16'h0fff);
        host.idle();
        for (int a = 0; a < 16; a++) begin
            host.rd_word(4'(a), d);
            `CHK(d, (a < 8) ? 16'(mem[a]) : (a == 8) ? 16'(ov) : 16'h0)
        end
        host.wr_word(ACTIVE_SETUP_OFS, 16'h0005);
        host.idle();
        ov = 5;
        host.rd_word(ACTIVE_SETUP_OFS, d);
        `CHK(d, 16'(ov))
        for (int s = 0; s < 8; s++) fe_check(s);
        reset_dut();
        host.rd_word(4'h3, d);
        `CHK(d, 16'h0860)
        fe_check(3);
        finish_test();
    end
    // Whole run is well under a thousand cycles
    initial begin
        #100us;
        n_fail++;
        finish_test();
    end
endmodule
`default_nettype wire
